/* File: rtl/scfp_fifo_pair.sv */
// external transmit and receive fifo pair beside a serial controller
`timescale 1ns/1ps
`include "scfp_defs.svh"

// Behaviour
// RQ1: select 0: receive requests on chan A wait line, transmit on terminal-ready line
// RQ2: select 1: transmit requests on chan A wait line, receive on chan B wait line
// RQ3: software sets request enable last in transfer control register
// RQ4: channel A only: request mode, receive direction, transmit interrupts off
// RQ5: receive interrupts special-condition only, or off
// RQ6: misc control bit 2 set when channel A receives
// RQ7: misc control bit 2 cleared when channel B receives
// RQ8: expose extended control, clear its bit 5 for empty-slot transmit requests
// RQ9: channel A only: terminal-ready line uses wait line timing
// RQ10: channel B receive: enable, request mode, receive direction set
// RQ11: events set sticky status bits, cleared only by writing one
// RQ12: fifo interrupts only when serial controller source selected
// RQ13: transmit bit 1 set when transmit fifo drains below half
// RQ14: receive bit 2 set when receive fifo fills past half
// RQ15: receive bit 2 also set on timeout with data present
// RQ16: bit 3 set on receive pattern match
// RQ17: half flag live; interrupt with flag clear means timeout
// RQ18: power-up and insertion disable and reset both fifos
// RQ19: each fifo reset by setting then clearing its reset bit
// RQ20: fifo reset shows empty and homes pointers
// RQ21: external fifo reset leaves controller internals alone
// RQ22: reset commands ignored while fifos enabled
// RQ23: live empty, full, half status of both fifos always shown
// RQ24: each fifo holds 1024 bytes
// RQ25: one bit enables both fifos together
// RQ26: host data port writes push transmit, reads pop receive
// RQ27: character time is eight bit clock ticks
// RQ28: one byte moved per request while enabled and room exists
// RQ29: each flag set once on entry into its condition
module scfp_fifo_pair
   import scfp_pkg::*;
#(
   parameter int DEPTH = `SCFP_DEPTH,
   parameter int HALF  = `SCFP_HALF_MARK,
   parameter int CHARS = `SCFP_TMO_CHARS
) (
   input  wire logic                      CORE_CLK,
   input  wire logic                      NRST,
   // configuration and control
   input  wire logic                      FIFO_PAIR_ENABLE,
   input  wire logic                      RX_SOURCE_SELECT,
   input  wire logic                      INTSRC_SERIAL_CONTROLLER,
   input  wire logic                      TX_RESET_BIT,
   input  wire logic                      RX_RESET_BIT,
   input  wire logic                      STATUS_CLEAR_WR,
   input  wire logic [`SCFP_ST_W-1:0]     STATUS_CLEAR_DATA,
   // host data port
   input  wire logic                      HOST_WR,
   input  wire logic [`SCFP_DATA_W-1:0]   HOST_WDATA,
   input  wire logic                      HOST_RD,
   output logic      [`SCFP_DATA_W-1:0]   HOST_RDATA,
   // controller request lines and byte path (pins)
   input  wire logic                      CHAN_A_WAIT_REQUEST,
   input  wire logic                      CHAN_A_TERMINAL_READY_REQUEST,
   input  wire logic                      CHAN_B_WAIT_REQUEST,
   input  wire logic                      BIT_CLK_PIN,
   input  wire logic [`SCFP_DATA_W-1:0]   CTRL_RDATA,
   output logic                           CTRL_RD,
   output logic                           CTRL_WR,
   output logic      [`SCFP_DATA_W-1:0]   CTRL_WDATA,
   // pattern detector match and status
   input  wire logic                      RX_MATCH_FLAG,
   output logic      [`SCFP_ST_W-1:0]     INT_STATUS,
   output logic                           INT_OUT,
   output scfp_level_type                 TX_LEVEL,
   output scfp_level_type                 RX_LEVEL
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic       tick_d_reg;
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         sync1_reg  <= '0;
         sync2_reg  <= '0;
         tick_d_reg <= 1'b0;
      end else begin
         sync1_reg  <= {BIT_CLK_PIN, RX_MATCH_FLAG, CHAN_B_WAIT_REQUEST,
                        CHAN_A_TERMINAL_READY_REQUEST, CHAN_A_WAIT_REQUEST};
         sync2_reg  <= sync1_reg;
         tick_d_reg <= sync2_reg[4];
      end
   end
   wire a_wait_s = sync2_reg[0];
   wire a_dtr_s  = sync2_reg[1];
   wire b_wait_s = sync2_reg[2];
   wire match_s  = sync2_reg[3];
   wire bit_tick = sync2_reg[4] && !tick_d_reg;

   // ----------------------------------------
   // request routing
   // ----------------------------------------
   wire rx_req = RX_SOURCE_SELECT ? b_wait_s : a_wait_s; // [RQ1] [RQ2]
   wire tx_req = RX_SOURCE_SELECT ? a_wait_s : a_dtr_s;  // [RQ1] [RQ2]

   // ----------------------------------------
   // fifo reset commands: set then clear, ignored while enabled
   // ----------------------------------------
   logic tx_rst_d_reg;
   logic rx_rst_d_reg;
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         tx_rst_d_reg <= 1'b0;
         rx_rst_d_reg <= 1'b0;
      end else begin
         tx_rst_d_reg <= TX_RESET_BIT;
         rx_rst_d_reg <= RX_RESET_BIT;
      end
   end
   // falling edge of the reset bit completes the command
   wire tx_clear = tx_rst_d_reg && !TX_RESET_BIT && !FIFO_PAIR_ENABLE; // [RQ19] [RQ22]
   wire rx_clear = rx_rst_d_reg && !RX_RESET_BIT && !FIFO_PAIR_ENABLE; // [RQ19] [RQ22]

   // ----------------------------------------
   // transfer engine
   // ----------------------------------------
   scfp_xfer_type  state_reg;
   scfp_xfer_type  state_next;
   scfp_level_type tx_lv;
   scfp_level_type rx_lv;
   logic [`SCFP_DATA_W-1:0] tx_head;
   logic [`SCFP_DATA_W-1:0] rx_head;

   wire en       = FIFO_PAIR_ENABLE; // [RQ25] both fifos share one enable
   wire start_rx = en && rx_req && !rx_lv.full;  // [RQ28]
   wire start_tx = en && tx_req && !tx_lv.empty; // [RQ28]

   // one byte per request, then wait for both request lines to drop
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SCFP_IDLE: begin
            if (start_rx) state_next = SCFP_RX_MOVE;
            else if (start_tx) state_next = SCFP_TX_MOVE;
         end
         SCFP_TX_MOVE: state_next = SCFP_WAIT_DROP;
         SCFP_RX_MOVE: state_next = SCFP_WAIT_DROP;
         SCFP_WAIT_DROP: begin
            if (!rx_req && !tx_req) state_next = SCFP_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) state_reg <= SCFP_IDLE;
      else state_reg <= state_next;
   end

   wire tx_pop  = (state_reg == SCFP_TX_MOVE);
   wire rx_push = (state_reg == SCFP_RX_MOVE);

   // controller strobes and data out of flip-flops
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         CTRL_WR    <= 1'b0;
         CTRL_RD    <= 1'b0;
         CTRL_WDATA <= '0;
      end else begin
         CTRL_WR    <= tx_pop;
         CTRL_RD    <= (state_next == SCFP_RX_MOVE) && (state_reg == SCFP_IDLE);
         if (tx_pop) CTRL_WDATA <= tx_head; // [RQ28]
      end
   end

   // ----------------------------------------
   // the two fifos; NRST covers power-up and insertion
   // ----------------------------------------
   scfp_fifo #(.DEPTH(DEPTH), .HALF(HALF)) u_tx_fifo ( // [RQ24]
      .clk   (CORE_CLK),
      .nrst  (NRST),          // [RQ18]
      .clear (tx_clear),      // [RQ20] [RQ21]
      .push  (HOST_WR && en), // [RQ26]
      .wdata (HOST_WDATA),
      .pop   (tx_pop),
      .rdata (tx_head),
      .level (tx_lv)
   );

   // receive byte is sampled while the read strobe is out
   scfp_fifo #(.DEPTH(DEPTH), .HALF(HALF)) u_rx_fifo ( // [RQ24]
      .clk   (CORE_CLK),
      .nrst  (NRST),          // [RQ18]
      .clear (rx_clear),      // [RQ20] [RQ21]
      .push  (rx_push),
      .wdata (CTRL_RDATA),
      .pop   (HOST_RD && en), // [RQ26]
      .rdata (rx_head),
      .level (rx_lv)
   );

   // ----------------------------------------
   // receive idle timeout
   // ----------------------------------------
   logic tmo;
   scfp_rx_timer #(.CHARS(CHARS)) u_timer (
      .clk      (CORE_CLK),
      .nrst     (NRST),
      .bit_tick (bit_tick),
      .restart  (rx_push),
      .armed    (!rx_lv.empty),
      .expired  (tmo)
   );

   // ----------------------------------------
   // event edges and sticky status
   // ----------------------------------------
   logic tx_low_d_reg;
   logic rx_half_d_reg;
   logic tmo_d_reg;
   logic match_d_reg;
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         tx_low_d_reg  <= 1'b1;
         rx_half_d_reg <= 1'b0;
         tmo_d_reg     <= 1'b0;
         match_d_reg   <= 1'b0;
      end else begin
         tx_low_d_reg  <= !tx_lv.half;
         rx_half_d_reg <= rx_lv.half;
         tmo_d_reg     <= tmo;
         match_d_reg   <= match_s;
      end
   end

   wire ev_tx  = !tx_lv.half && !tx_low_d_reg;           // [RQ13] [RQ29]
   wire ev_rx  = (rx_lv.half && !rx_half_d_reg)          // [RQ14] [RQ29]
               || (tmo && !tmo_d_reg);                  // [RQ15]
   wire ev_pat = match_s && !match_d_reg;                // [RQ16] [RQ29]
   wire gate   = INTSRC_SERIAL_CONTROLLER && en;         // [RQ12]

   logic [`SCFP_ST_W-1:0] set_vec;
   logic [`SCFP_ST_W-1:0] clr_vec;
   logic [`SCFP_ST_W-1:0] status_next;
   assign set_vec = {ev_pat, ev_rx, ev_tx, 1'b0} & {`SCFP_ST_W{gate}};
   assign clr_vec = STATUS_CLEAR_WR ? STATUS_CLEAR_DATA : '0;
   // set wins over a clear in the same cycle
   assign status_next = (INT_STATUS & ~clr_vec) | set_vec; // [RQ11]

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         INT_STATUS <= '0;
         INT_OUT    <= 1'b0;
      end else begin
         INT_STATUS <= status_next;                            // [RQ11]
         INT_OUT    <= INTSRC_SERIAL_CONTROLLER && (|status_next); // [RQ12]
      end
   end

   // live level flags and host read data, registered
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         TX_LEVEL   <= '{empty: 1'b1, full: 1'b0, half: 1'b0};
         RX_LEVEL   <= '{empty: 1'b1, full: 1'b0, half: 1'b0};
         HOST_RDATA <= '0;
      end else begin
         TX_LEVEL <= tx_lv; // [RQ23]
         RX_LEVEL <= rx_lv; // [RQ17] [RQ23]
         if (HOST_RD && en) HOST_RDATA <= rx_head;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_clear_cmd;
      tx_rst_d_reg && !TX_RESET_BIT && !FIFO_PAIR_ENABLE;
   endsequence

   a_tx_reset_empty: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ20]
      s_clear_cmd |=> tx_lv.empty) else $error("tx fifo not empty after reset command");
   a_reset_ignored: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ22]
      (FIFO_PAIR_ENABLE && rx_rst_d_reg && !RX_RESET_BIT && !rx_lv.empty && !HOST_RD)
      |=> !rx_lv.empty) else $error("rx fifo cleared while enabled");
   a_sticky_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ11]
      (INT_STATUS[`SCFP_ST_MATCH] && !(STATUS_CLEAR_WR && STATUS_CLEAR_DATA[`SCFP_ST_MATCH]))
      |=> INT_STATUS[`SCFP_ST_MATCH]) else $error("status bit dropped without clear");
   a_set_wins: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ11]
      ev_pat && gate |=> INT_STATUS[`SCFP_ST_MATCH]) else $error("pattern event lost");
   a_no_src_int: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ12]
      !INTSRC_SERIAL_CONTROLLER |=> !INT_OUT) else $error("interrupt with other source");
   a_tx_half_set: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ13]
      (ev_tx && gate) |=> INT_STATUS[`SCFP_ST_TX_FIFO]) else $error("tx half event lost");
   a_rx_route: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ2]
      (state_reg == SCFP_IDLE && en && RX_SOURCE_SELECT && b_wait_s && !rx_lv.full)
      |=> state_reg == SCFP_RX_MOVE) else $error("chan b request not served");
   a_one_byte: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ28]
      tx_pop |=> !tx_pop ##1 !tx_pop) else $error("more than one byte per request");
   a_disabled_idle: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RQ25]
      (state_reg == SCFP_IDLE && !en) |=> state_reg == SCFP_IDLE)
      else $error("transfer while disabled");
endmodule // scfp_fifo_pair

/* File: shared/scfp_defs.svh */
// constants for the serial controller external fifo pair
`ifndef SCFP_DEFS_SVH
`define SCFP_DEFS_SVH

// ----------------------------------------
// fifo geometry
// ----------------------------------------
`define SCFP_DATA_W        8
`define SCFP_DEPTH         1024
`define SCFP_HALF_MARK     512

// ----------------------------------------
// interrupt status bit positions
// ----------------------------------------
`define SCFP_ST_TX_FIFO    1
`define SCFP_ST_RX_FIFO    2
`define SCFP_ST_MATCH      3
`define SCFP_ST_W          4

// ----------------------------------------
// timing
// ----------------------------------------
`define SCFP_TICKS_PER_CHAR 8
`define SCFP_TMO_CHARS      4

`endif

/* File: shared/scfp_pkg.sv */
// types for the serial controller external fifo pair
package scfp_pkg;

   // ----------------------------------------
   // live level flags of one fifo
   // ----------------------------------------
   typedef struct packed {
      logic empty;
      logic full;
      logic half;
   } scfp_level_type;

   // ----------------------------------------
   // transfer engine states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SCFP_IDLE,
      SCFP_TX_MOVE,
      SCFP_RX_MOVE,
      SCFP_WAIT_DROP
   } scfp_xfer_type;

endpackage

/* File: rtl/scfp_fifo.sv */
// one byte-wide flip-flop fifo with synchronous clear and live level flags
`timescale 1ns/1ps
`include "scfp_defs.svh"
module scfp_fifo
   import scfp_pkg::*;
#(
   parameter int DATA_W = `SCFP_DATA_W,
   parameter int DEPTH  = `SCFP_DEPTH,
   parameter int HALF   = `SCFP_HALF_MARK
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 clear,
   input  wire logic                 push,
   input  wire logic [DATA_W-1:0]    wdata,
   input  wire logic                 pop,
   output logic      [DATA_W-1:0]    rdata,
   output scfp_level_type            level
);
   localparam int AW = $clog2(DEPTH);

   logic [DATA_W-1:0] mem_reg [DEPTH];
   logic [AW-1:0]     wptr_reg;
   logic [AW-1:0]     rptr_reg;
   logic [AW:0]       count_reg;
   wire               do_push = push && (count_reg != DEPTH[AW:0]);
   wire               do_pop  = pop && (count_reg != '0);

   // ----------------------------------------
   // pointers and count
   // ----------------------------------------
   // clear returns pointers home and shows empty
   always_ff @(posedge clk) begin
      if (!nrst || clear) begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         count_reg <= '0;
      end else begin
         if (do_push) wptr_reg <= wptr_reg + 1'b1;
         if (do_pop) rptr_reg <= rptr_reg + 1'b1;
         count_reg <= count_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      end
   end

   // storage write
   always_ff @(posedge clk) begin
      if (do_push) mem_reg[wptr_reg] <= wdata;
   end

   // live flags and read data
   assign rdata       = mem_reg[rptr_reg];
   assign level.empty = (count_reg == '0);
   assign level.full  = (count_reg == DEPTH[AW:0]);
   assign level.half  = (count_reg >= HALF[AW:0]);
endmodule // scfp_fifo

/* File: rtl/scfp_rx_timer.sv */
// receive idle timeout counted in bit clock ticks
`timescale 1ns/1ps
`include "scfp_defs.svh"
module scfp_rx_timer #(
   parameter int TICKS = `SCFP_TICKS_PER_CHAR,
   parameter int CHARS = `SCFP_TMO_CHARS
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic bit_tick,
   input  wire logic restart,
   input  wire logic armed,
   output logic      expired
);
   localparam int LIMIT = TICKS * CHARS;
   localparam int CW    = $clog2(LIMIT + 1);
   logic [CW-1:0] cnt_reg;

   // ----------------------------------------
   // tick counter, held off while idle or restarted
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst || restart || !armed) cnt_reg <= '0;
      else if (bit_tick && cnt_reg != LIMIT[CW-1:0]) cnt_reg <= cnt_reg + 1'b1; // [RQ27]
   end

   assign expired = armed && (cnt_reg == LIMIT[CW-1:0]);
endmodule // scfp_rx_timer

/* File: verification/scfp_ctrl_model.sv */
// serial controller model on the far side of the fifo pair
`timescale 1ns/1ps
module scfp_ctrl_model (
   input  wire logic       clk,
   input  wire logic       sel,
   input  wire logic       rd,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   output logic            a_wait,
   output logic            a_term,
   output logic            b_wait,
   output logic [7:0]      rdata
);
   logic rx_req;
   logic tx_req;
   // ------
   // request pin routing
   // ------
   // both channel a lines share one request timing
   assign a_wait = sel ? tx_req : rx_req;
   assign a_term = sel ? 1'b0 : tx_req;
   assign b_wait = sel ? rx_req : 1'b0;
   // idle pins at time zero
   initial begin
      rx_req = 1'b0;
      tx_req = 1'b0;
      rdata  = 8'h00;
   end
   // offer one byte, held until the read strobe is seen
   task automatic send_rx(input logic [7:0] b, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      #1 rx_req = 1'b1;
      rdata = b;
      do begin
         @(posedge clk);
         n++;
      end while (rd !== 1'b1 && n < 40);
      ok = (rd === 1'b1);
      #1 rx_req = 1'b0;
      rdata = ~b; // released bus shows no stale byte
      repeat (4) @(posedge clk);
      #1;
   endtask
   // ask for one byte, held until the write strobe is seen
   task automatic take_tx(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      #1 tx_req = 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (wr !== 1'b1 && n < 40);
      ok = (wr === 1'b1);
      b = wdata;
      #1 tx_req = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
endmodule // scfp_ctrl_model

/* File: verification/scfp_fifo_pair_test.sv */
// self-checking bench for the serial controller fifo pair
`timescale 1ns/1ps
`include "scfp_defs.svh"
module scfp_fifo_pair_test import scfp_pkg::*;;
   localparam int DP = 16;
   localparam int HF = 8;
   localparam int CH = 2;
   logic clk, nrst, en, sel, isrc, txr, rxr, scw, hwr, hrd, bclk, mat;
   logic crd, cwr, aw, at, bw, iout, ok;
   logic [3:0] scd, ist;
   logic [7:0] hwd, hrdata, crdata, cwdata, b;
   scfp_level_type txl, rxl;
   int n_errors, checks_done;
   // ------
   // design and controller model
   // ------
   scfp_fifo_pair #(.DEPTH(DP), .HALF(HF), .CHARS(CH)) dut (
      .CORE_CLK(clk), .NRST(nrst), .FIFO_PAIR_ENABLE(en),
      .RX_SOURCE_SELECT(sel), .INTSRC_SERIAL_CONTROLLER(isrc),
      .TX_RESET_BIT(txr), .RX_RESET_BIT(rxr),
      .STATUS_CLEAR_WR(scw), .STATUS_CLEAR_DATA(scd),
      .HOST_WR(hwr), .HOST_WDATA(hwd), .HOST_RD(hrd), .HOST_RDATA(hrdata),
      .CHAN_A_WAIT_REQUEST(aw), .CHAN_A_TERMINAL_READY_REQUEST(at),
      .CHAN_B_WAIT_REQUEST(bw), .BIT_CLK_PIN(bclk), .CTRL_RDATA(crdata),
      .CTRL_RD(crd), .CTRL_WR(cwr), .CTRL_WDATA(cwdata),
      .RX_MATCH_FLAG(mat), .INT_STATUS(ist), .INT_OUT(iout),
      .TX_LEVEL(txl), .RX_LEVEL(rxl));
   scfp_ctrl_model ctl (.clk(clk), .sel(sel), .rd(crd), .wr(cwr),
      .wdata(cwdata), .a_wait(aw), .a_term(at), .b_wait(bw), .rdata(crdata));
   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------
   // helpers
   // ------
   task automatic ck(input logic c, input string m);
      checks_done++;
      if (!c) begin
         n_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic hw(input logic [7:0] d);
      hwr = 1'b1;
      hwd = d;
      cyc(1);
      hwr = 1'b0;
      cyc(1);
   endtask
   task automatic hr(input logic [7:0] e);
      hrd = 1'b1;
      cyc(1);
      hrd = 1'b0;
      ck(hrdata === e, "host read data");
      cyc(1);
   endtask
   task automatic sclr(input logic [3:0] m);
      scw = 1'b1;
      scd = m;
      cyc(1);
      scw = 1'b0;
      cyc(2);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         bclk = 1'b1;
         cyc(3);
         bclk = 1'b0;
         cyc(3);
      end
   endtask
   task automatic rp(input logic tx);
      txr = tx;
      rxr = ~tx;
      cyc(2);
      txr = 1'b0;
      rxr = 1'b0;
      cyc(3);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset();
      ck(txl === 3'b100 && rxl === 3'b100, "levels after reset");
      ck(ist === 4'h0 && iout === 1'b0, "status after reset");
      hw(8'h11);
      cyc(3);
      ck(txl.empty === 1'b1, "write while disabled");
   endtask
   task automatic t_tx();
      en = 1'b1;
      isrc = 1'b1;
      cyc(1);
      for (int i = 0; i < HF + 1; i++) hw(8'h40 + 8'(i));
      cyc(2);
      ck(txl.half === 1'b1 && ist === 4'h0, "tx half level");
      for (int i = 0; i < HF + 1; i++) begin
         ctl.take_tx(b, ok);
         ck(ok === 1'b1 && b === 8'h40 + 8'(i), "tx byte");
         ck(ist[1] === (i == 1), "tx drained flag");
         if (i == 1) sclr(4'h2);
         if (i == 0) ck(iout === 1'b0, "no early int");
      end
      ck(txl.empty === 1'b1, "tx empty");
      ctl.take_tx(b, ok);
      ck(ok === 1'b0, "no move from empty tx");
   endtask
   task automatic t_rx();
      sel = 1'b1;
      sclr(4'hf);
      for (int i = 0; i < DP; i++) begin
         ctl.send_rx(8'ha0 + 8'(i), ok);
         ck(ok === 1'b1, "rx fetch on chan b");
         ck(ist[2] === (i >= HF - 1), "rx half flag");
      end
      ck(rxl.full === 1'b1 && iout === 1'b1, "rx full");
      ctl.send_rx(8'h55, ok);
      ck(ok === 1'b0, "no move into full rx");
      for (int i = 0; i < DP; i++) hr(8'ha0 + 8'(i));
      ck(rxl.empty === 1'b1, "rx drained");
      hw(8'h77);
      ctl.take_tx(b, ok);
      ck(ok === 1'b1 && b === 8'h77, "tx on chan a wait");
   endtask
   task automatic t_tmo();
      sel = 1'b0;
      sclr(4'hf);
      ctl.send_rx(8'h5a, ok);
      ck(ok === 1'b1, "rx fetch on chan a");
      tick(CH * `SCFP_TICKS_PER_CHAR - 1);
      ck(ist[2] === 1'b0, "early timeout");
      tick(1);
      ck(ist[2] === 1'b1 && rxl.half === 1'b0, "timeout flag");
      hr(8'h5a);
      sclr(4'h4);
      tick(CH * 8 + 2);
      ck(ist[2] === 1'b0, "timeout with empty rx");
   endtask
   task automatic t_pat();
      isrc = 1'b0;
      mat = 1'b1;
      cyc(4);
      ck(ist === 4'h0 && iout === 1'b0, "source gate");
      mat = 1'b0;
      isrc = 1'b1;
      cyc(4);
      mat = 1'b1;
      cyc(4);
      ck(ist[3] === 1'b1 && iout === 1'b1, "pattern flag");
      sclr(4'h0);
      ck(ist[3] === 1'b1, "zero write keeps flag");
      sclr(4'h8);
      cyc(3);
      ck(ist === 4'h0, "one write clears");
      mat = 1'b0;
   endtask
   task automatic t_clr();
      hw(8'h01);
      ctl.send_rx(8'h02, ok);
      rp(1'b0);
      ck(rxl.empty === 1'b0, "reset while enabled");
      en = 1'b0;
      cyc(1);
      rp(1'b0);
      ck(rxl.empty === 1'b1 && txl.empty === 1'b0, "rx reset alone");
      rp(1'b1);
      ck(txl.empty === 1'b1, "tx reset");
      en = 1'b1;
      hw(8'h03);
      ctl.take_tx(b, ok);
      ck(ok === 1'b1 && b === 8'h03, "pointers home");
      hw(8'h04);
      nrst = 1'b0;
      cyc(3);
      nrst = 1'b1;
      cyc(1);
      ck(txl === 3'b100 && ist === 4'h0, "second reset");
   endtask
   // ------
   // run control
   // ------
   task automatic end_sim();
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {en, sel, isrc, txr, rxr, scw, hwr, hrd, bclk, mat} = '0;
      scd = 4'h0;
      hwd = 8'h00;
      nrst = 1'b0;
      n_errors = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_tmo();
      t_pat();
      t_clr();
      end_sim();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule // scfp_fifo_pair_test
